// ==== bench/link_partner.sv ====
`timescale 1ns/1ps
// Even ports answer promptly, odd ports a cycle later
module link_partner (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_req,
  input  wire logic [11:0] i_cmd,
  output logic [3:0]       o_sent,
  output logic [3:0]       o_expect,
  output logic [3:0]       o_rvalid,
  output logic [39:0]      o_rdata
);
  logic [3:0]  d1_q;
  logic [3:0]  d2_q;
  logic [39:0] dat_q;
  assign o_expect = 4'h3;
  // Fields are only meaningful with a strobe
  assign o_rdata = |o_rvalid ? dat_q : ~dat_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {d1_q, d2_q, o_sent, o_rvalid, dat_q} <= '0;
    end else begin
      d1_q <= i_req;
      d2_q <= d1_q & i_req;
      o_sent <= i_req & ~o_sent & ((d1_q & 4'h5) | (d2_q & 4'ha));
      o_rvalid <= o_sent & o_expect;
      for (int p = 0; p < 4; p++) dat_q[10*p+:10] <= {5'(17 + p), 2'h0, i_cmd[3*p+:3]};
    end
  end
endmodule // link_partner

// ==== bench/port_timeout_maint_control_asserts.sv ====
`timescale 1ns/1ps
module port_timeout_maint_control_asserts (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [3:0]  o_lreq_valid,
  input wire logic [11:0] o_lreq_cmd,
  input wire logic [3:0]  i_lreq_sent,
  input wire logic        o_host,
  input wire logic        o_req_enable,
  input wire logic        o_discovered
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire acc = i_psel & i_penable & ~o_pready;
  wire wr0 = acc & i_pwrite & (i_paddr == port_ctl_pkg::ADDR_LM_REQ0);
  wire wr3 = acc & i_pwrite & (i_paddr == 12'h04c);
  wire wg  = acc & i_pwrite & (i_paddr == port_ctl_pkg::ADDR_GEN_CTL);
  chk_one_wait: assert property (acc |=> o_pready) else $error("pready late");
  chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
  chk_unmapped_err: assert property (acc && i_paddr == 12'h010 |=> o_pslverr) else $error("no slverr");
  chk_req_raise: assert property (wr0 |=> o_lreq_valid[0] && o_lreq_cmd[2:0] == $past(i_pwdata[2:0]))
    else $error("req not raised");
  chk_req_port3: assert property (wr3 |=> o_lreq_valid[3] && o_lreq_cmd[11:9] == $past(i_pwdata[2:0]))
    else $error("port3 req");
  chk_req_cause: assert property ($rose(o_lreq_valid[0]) |-> $past(wr0)) else $error("req without write");
  chk_req_hold: assert property (o_lreq_valid[0] && !i_lreq_sent[0] |=> o_lreq_valid[0]) else $error("req lost");
  chk_req_single: assert property (o_lreq_valid[0] && i_lreq_sent[0] && !wr0 |=> !o_lreq_valid[0])
    else $error("req repeated");
  chk_gen_write: assert property (wg |=> {o_host, o_req_enable, o_discovered} == $past(i_pwdata[31:29]))
    else $error("gen ctl write");
  chk_gen_hold: assert property (!wg |=> $stable({o_host, o_req_enable, o_discovered}))
    else $error("gen ctl moved");
  cover property (wr0);
  cover property (o_lreq_valid[0] && i_lreq_sent[0]);
  cover property (wg);
endmodule // port_timeout_maint_control_asserts
bind port_timeout_maint_control port_timeout_maint_control_asserts u_chk (.*);

// ==== bench/tb_port_timeout_maint_control.sv ====
`timescale 1ns/1ps
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_port_timeout_maint_control;
  logic i_clk, i_rstn, psel, pen, pwr, rdy, serr;
  logic [11:0] addr, cmd;
  logic [31:0] wd, rdat;
  logic [3:0] lv, sent, expr, rv, rs, rr, terr;
  logic [39:0] rdata;
  logic host, men, disc, slv;
  logic [31:0] scratch;
  int checks, err_total, nsent[4];
  port_timeout_maint_control dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(serr),
    .o_lreq_valid(lv), .o_lreq_cmd(cmd), .i_lreq_sent(sent), .i_lreq_expect_resp(expr),
    .i_lresp_valid(rv), .i_lresp_data(rdata), .i_req_sent(rs), .i_resp_rcvd(rr), .o_host(host),
    .o_req_enable(men), .o_discovered(disc), .o_timeout_err(terr));
  link_partner u_far (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(lv), .i_cmd(cmd), .o_sent(sent),
    .o_expect(expr), .o_rvalid(rv), .o_rdata(rdata));
  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) for (int p = 0; p < 4; p++) if (sent[p] === 1'b1) nsent[p]++;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge i_clk) {psel, pen, pwr, addr, wd} <= {2'b10, w, a, d};
    @(posedge i_clk) pen <= 1'b1;
    do @(posedge i_clk); while (rdy !== 1'b1);
    r = rdat;
    e = serr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CK(n, x, r)
  endtask
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timer(input logic [31:0] ps, input int quiet, input int late);
    wr(12'h020, ps);
    @(posedge i_clk) rs <= 4'h3;
    @(posedge i_clk) rs <= 4'h0;
    repeat (2) @(posedge i_clk);
    rr <= 4'h2;
    @(posedge i_clk) rr <= 4'h0;
    repeat (quiet) @(posedge i_clk);
    `CK("early", 4'h0, terr)
    repeat (late) @(posedge i_clk);
    `CK("terr", 4'h1, terr)
    rd("tstat", 12'h024, 32'h1);
    wr(12'h024, 32'h1);
    rd("tclr", 12'h024, 32'h0);
  endtask
  initial begin
    {i_rstn, psel, pen, pwr, addr, wd, rs, rr} = '0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd("rt", 12'h000, 32'hffffff00);
    rd("gen", 12'h004, 32'h0);
    wr(12'h004, 32'hffffffff);
    rd("gen", 12'h004, 32'he0000000);
    `CK("flags", 3'b111, {host, men, disc})
    wr(12'h004, 32'h40000000);
    `CK("flags", 3'b010, {host, men, disc})
    wr(12'h000, 32'h000002ff);
    rd("rt", 12'h000, 32'h00000200);
    // Results go to scratch variables, never to the bus signals the master drives
    apb(1'b0, 12'h010, 32'h0, scratch, slv);
    `CK("slverr", 1'b1, slv)
    `CK("unmapped", 32'h0, scratch)
    for (int p = 0; p < 4; p++) begin
      wr(12'h040 + 12'(4 * p), 32'hfffffff8 | (p + 5));
      repeat (8) @(posedge i_clk);
      rd("req", 12'h040 + 12'(4 * p), 32'((p + 5) % 8));
      rd("resp", 12'h060 + 12'(4 * p), p < 2 ? {1'b1, 21'h0, 5'(17 + p), 2'h0, 3'(p + 5)} : 32'h80000000);
      rd("rclr", 12'h060 + 12'(4 * p), p < 2 ? {22'h0, 5'(17 + p), 2'h0, 3'(p + 5)} : 32'h0);
      `CK("nsent", 1, nsent[p])
    end
    timer(32'h0, 12, 23);
    timer(32'h1, 26, 40);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    close_out;
  end
endmodule // tb_port_timeout_maint_control

// ==== core/port_ctl_pkg.sv ====
package port_ctl_pkg;
  localparam int          NUM_PORTS       = 4;
  localparam logic [11:0] ADDR_RT_CTL     = 12'h000;
  localparam logic [11:0] ADDR_GEN_CTL    = 12'h004;
  localparam logic [11:0] ADDR_PRESCALE   = 12'h020;
  localparam logic [11:0] ADDR_TO_STATUS  = 12'h024;
  localparam logic [11:0] ADDR_LM_REQ0    = 12'h040;
  localparam logic [11:0] ADDR_LM_RESP0   = 12'h060;
  localparam logic [11:0] PORT_STRIDE     = 12'h004;
  localparam int          TO_MSB          = 31;
  localparam int          TO_LSB          = 8;
  localparam logic [23:0] TO_RESET        = 24'hffffff;
  localparam int          HOST_BIT        = 31;
  localparam int          MEN_BIT         = 30;
  localparam int          DISC_BIT        = 29;
  localparam int          RV_BIT          = 31;
  localparam int          PRESCALE_W      = 4;
  localparam logic [3:0]  PRESCALE_RESET  = 4'h0;
  localparam logic [3:0]  TICK_MULT       = 4'hf;
  localparam logic [2:0]  CMD_RESET       = 3'h0;

  typedef struct packed {
    logic [4:0] ackid;
    logic [4:0] status;
  } link_resp_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] cmd;
  } link_req_t;
endpackage

// ==== core/port_timeout_maint_control.sv ====
`timescale 1ns/1ps
module port_timeout_maint_control (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [3:0]       o_lreq_valid,
  output logic [11:0]      o_lreq_cmd,
  input  wire logic [3:0]  i_lreq_sent,
  input  wire logic [3:0]  i_lreq_expect_resp,
  input  wire logic [3:0]  i_lresp_valid,
  input  wire logic [39:0] i_lresp_data,
  input  wire logic [3:0]  i_req_sent,
  input  wire logic [3:0]  i_resp_rcvd,
  output logic             o_host,
  output logic             o_req_enable,
  output logic             o_discovered,
  output logic [3:0]       o_timeout_err
);
  localparam int NP = port_ctl_pkg::NUM_PORTS;

  logic [23:0] to_val_q;
  logic [3:0]  prescale_q;
  logic        host_q, men_q, disc_q;
  logic [3:0]  pre_cnt_q;
  logic [3:0]  mult_cnt_q;
  logic        tick_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic [3:0]  to_sticky_q;
  logic [3:0]  expired;
  logic [NP-1:0] rv_q;
  logic [NP-1:0] lreq_v_q;
  logic [NP-1:0] pending_q;
  logic [2:0]  cmd_q [NP];
  port_ctl_pkg::link_resp_t resp_q [NP];

  wire access = i_psel && i_penable && !pready_q;
  wire wr     = access && i_pwrite;
  wire rd     = access && !i_pwrite;
  wire sel_rt = (i_paddr == port_ctl_pkg::ADDR_RT_CTL);
  wire sel_gc = (i_paddr == port_ctl_pkg::ADDR_GEN_CTL);
  wire sel_ps = (i_paddr == port_ctl_pkg::ADDR_PRESCALE);
  wire sel_ts = (i_paddr == port_ctl_pkg::ADDR_TO_STATUS);
  logic [NP-1:0] sel_req, sel_resp;
  logic [31:0]   rd_port;
  logic          hit_port;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      localparam logic [11:0] OFS = port_ctl_pkg::PORT_STRIDE * 12'(g);
      wire lresp_hit = i_lresp_valid[g];
      wire sent_hit  = i_lreq_sent[g] && !i_lreq_expect_resp[g];
      wire rv_clr    = rd && sel_resp[g];
      assign sel_req[g]  = (i_paddr == port_ctl_pkg::ADDR_LM_REQ0 + OFS);
      assign sel_resp[g] = (i_paddr == port_ctl_pkg::ADDR_LM_RESP0 + OFS);

      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cmd_q[g]    <= port_ctl_pkg::CMD_RESET;
          lreq_v_q[g] <= 1'b0;
          rv_q[g]     <= 1'b0;
          resp_q[g]   <= '0;
          pending_q[g] <= 1'b0;
        end else begin
          if (wr && sel_req[g]) begin
            cmd_q[g]    <= i_pwdata[2:0];
            lreq_v_q[g] <= 1'b1;
          end else if (i_lreq_sent[g]) begin
            lreq_v_q[g] <= 1'b0;
          end
          if (i_lreq_sent[g])
            pending_q[g] <= i_lreq_expect_resp[g];
          else if (lresp_hit)
            pending_q[g] <= 1'b0;
          if (lresp_hit)
            resp_q[g] <= i_lresp_data[g*10 +: 10];
          // Set wins over the read clear
          if (lresp_hit || sent_hit)
            rv_q[g] <= 1'b1;
          else if (rv_clr)
            rv_q[g] <= 1'b0;
        end
      end

      resp_timer u_timer (
        .i_clk     (i_clk),
        .i_rstn    (i_rstn),
        .i_tick    (tick_q),
        .i_start   (i_req_sent[g]),
        .i_done    (i_resp_rcvd[g]),
        .i_limit   (to_val_q),
        .o_expired (expired[g])
      );

      assign o_lreq_cmd[g*3 +: 3] = cmd_q[g];
    end
  endgenerate

  always_comb begin
    rd_port  = 32'h00000000;
    hit_port = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (sel_req[i]) begin
        rd_port  = {29'h0, cmd_q[i]};
        hit_port = 1'b1;
      end
      if (sel_resp[i]) begin
        rd_port  = {rv_q[i], 21'h0, resp_q[i]};
        hit_port = 1'b1;
      end
    end
  end

  wire        mapped = sel_rt || sel_gc || sel_ps || sel_ts || hit_port;
  wire [31:0] rd_mux = sel_rt ? {to_val_q, 8'h00} :
                       sel_gc ? {host_q, men_q, disc_q, 29'h0} :
                       sel_ps ? {28'h0, prescale_q} :
                       sel_ts ? {28'h0, to_sticky_q} : rd_port;

  // Shared timebase: one tick every 15*(prescale+1) clocks
  wire pre_wrap  = (pre_cnt_q == prescale_q);
  wire mult_wrap = (mult_cnt_q == port_ctl_pkg::TICK_MULT - 4'h1);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_cnt_q  <= 4'h0;
      mult_cnt_q <= 4'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= pre_wrap && mult_wrap;
      pre_cnt_q <= pre_wrap ? 4'h0 : pre_cnt_q + 4'h1;
      if (pre_wrap)
        mult_cnt_q <= mult_wrap ? 4'h0 : mult_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      to_val_q   <= port_ctl_pkg::TO_RESET;
      prescale_q <= port_ctl_pkg::PRESCALE_RESET;
      host_q     <= 1'b0;
      men_q      <= 1'b0;
      disc_q     <= 1'b0;
    end else if (wr) begin
      if (sel_rt)
        to_val_q <= i_pwdata[port_ctl_pkg::TO_MSB:port_ctl_pkg::TO_LSB];
      if (sel_ps)
        prescale_q <= i_pwdata[port_ctl_pkg::PRESCALE_W-1:0];
      if (sel_gc) begin
        host_q <= i_pwdata[port_ctl_pkg::HOST_BIT];
        men_q  <= i_pwdata[port_ctl_pkg::MEN_BIT];
        disc_q <= i_pwdata[port_ctl_pkg::DISC_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      to_sticky_q <= 4'h0;
    end else begin
      // Write one to clear; new expiry wins
      to_sticky_q <= expired | (to_sticky_q & ~((wr && sel_ts) ? i_pwdata[3:0] : 4'h0));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !mapped;
      if (rd)
        prdata_q <= mapped ? rd_mux : 32'h00000000;
    end
  end

  assign o_prdata      = prdata_q;
  assign o_pready      = pready_q;
  assign o_pslverr     = pslverr_q;
  assign o_lreq_valid  = lreq_v_q;
  assign o_host        = host_q;
  assign o_req_enable  = men_q;
  assign o_discovered  = disc_q;
  assign o_timeout_err = to_sticky_q;
endmodule // port_timeout_maint_control

// ==== core/resp_timer.sv ====
`timescale 1ns/1ps
// One response timer per port; counts shared timebase ticks
module resp_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_tick,
  input  wire logic        i_start,
  input  wire logic        i_done,
  input  wire logic [23:0] i_limit,
  output logic             o_expired
);
  logic        busy_q;
  logic [23:0] cnt_q;
  logic        exp_q;
  wire         hit = busy_q && i_tick && (cnt_q == i_limit - 24'h000001);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
      cnt_q  <= 24'h000000;
      exp_q  <= 1'b0;
    end else begin
      exp_q <= hit && !i_done;
      if (i_start) begin
        // Zero count disables the timer
        busy_q <= (i_limit != 24'h000000);
        cnt_q  <= 24'h000000;
      end else if (i_done || hit) begin
        busy_q <= 1'b0;
      end else if (busy_q && i_tick) begin
        cnt_q <= cnt_q + 24'h000001;
      end
    end
  end

  assign o_expired = exp_q;
endmodule // resp_timer
